// ---- verilog/sqa_pkg.sv ----
// Shared constants and types for the SRAM service-level port arbiter.
// Assumes a single system clock and a 32-bit AHB-Lite register bus.
package sqa_pkg;

   // ------------------------------------------------------------
   // Ports, widths, service levels
   // ------------------------------------------------------------
   localparam int unsigned NPORT  = 9;
   localparam int unsigned PW     = 4;
   localparam int unsigned RAM_AW = 15;
   typedef logic [1:0] sqa_level_t;
   localparam sqa_level_t LVL_BACKGROUND = 2'h0;
   localparam sqa_level_t LVL_BANDWIDTH  = 2'h1;
   localparam sqa_level_t LVL_LATENCY    = 2'h2;
   localparam sqa_level_t LVL_CRITICAL   = 2'h3;
   localparam logic [PW-1:0] PORT_CPU   = 4'h0;
   localparam logic [PW-1:0] PORT_DEBUG = 4'h1;
   localparam logic [PW-1:0] PORT_DMAD  = 4'h2;
   localparam logic [PW-1:0] PORT_USB   = 4'h7;
   localparam logic [PW-1:0] PORT_TRACE = 4'h8;

   // ------------------------------------------------------------
   // Matrix master and slave numbering
   // ------------------------------------------------------------
   typedef logic [2:0] sqa_slave_t;
   localparam sqa_slave_t SLV_FLASH    = 3'h0;
   localparam sqa_slave_t SLV_SRAM_CPU = 3'h1;
   localparam sqa_slave_t SLV_SRAM_DBG = 3'h2;
   localparam sqa_slave_t SLV_BRIDGE_B = 3'h3;
   localparam sqa_slave_t SLV_BRIDGE_A = 3'h4;
   localparam sqa_slave_t SLV_BRIDGE_C = 3'h5;
   localparam sqa_slave_t SLV_SRAM_DMA = 3'h6;
   localparam sqa_slave_t SLV_NONE     = 3'h7;
   localparam logic [1:0] MST_CPU   = 2'h0;
   localparam logic [1:0] MST_DEBUG = 2'h1;
   localparam logic [1:0] MST_DMA   = 2'h2;
   localparam logic [1:0] MST_NONE  = 2'h3;

   // ------------------------------------------------------------
   // Address map regions
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      RGN_FLASH, RGN_RWSEC, RGN_SRAM, RGN_BRIDGE_A, RGN_BRIDGE_B, RGN_BRIDGE_C,
      RGN_IOPORT, RGN_NONE
   } sqa_region_t;
   localparam logic [31:0] BASE_FLASH    = 32'h0000_0000;
   localparam logic [31:0] BASE_RWSEC    = 32'h0040_0000;
   localparam logic [31:0] BASE_SRAM     = 32'h2000_0000;
   localparam logic [31:0] BASE_BRIDGE_A = 32'h4000_0000;
   localparam logic [31:0] BASE_BRIDGE_B = 32'h4100_0000;
   localparam logic [31:0] BASE_BRIDGE_C = 32'h4200_0000;
   localparam logic [31:0] BASE_IOPORT   = 32'h6000_0000;
   localparam logic [31:0] SIZE_FLASH    = 32'h0004_0000;
   localparam logic [31:0] SIZE_RWSEC    = 32'h0000_2000;
   localparam logic [31:0] SIZE_SRAM     = 32'h0000_8000;
   localparam logic [31:0] SIZE_BRIDGE   = 32'h0001_0000;
   localparam logic [31:0] SIZE_IOPORT   = 32'h0000_0200;

   // ------------------------------------------------------------
   // Registers: addresses and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_DEBUG_LVL = 32'h4100_201c;
   localparam logic [31:0] ADDR_CPU_LVL   = 32'h4100_c114;
   localparam logic [31:0] ADDR_LVL_CTRL  = 32'h4100_c118;
   localparam logic [31:0] ADDR_STATUS    = 32'h4100_c11c;
   localparam sqa_level_t  RST_CPU_LVL    = LVL_CRITICAL;
   localparam sqa_level_t  RST_DEBUG_LVL  = LVL_LATENCY;
   // Usb 3 in [7:6]; every dma field 2
   localparam logic [7:0]  RST_LVL_CTRL   = 8'hea;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;
   localparam int unsigned CTL_DMAD = 0;
   localparam int unsigned CTL_FTCH = 2;
   localparam int unsigned CTL_WRB  = 4;
   localparam int unsigned CTL_USB  = 6;

   // Matrix master id of a RAM port; direct ports have none
   function automatic logic [1:0] portMaster(input logic [PW-1:0] p);
      if (p == PORT_CPU) return MST_CPU;
      else if (p == PORT_DEBUG) return MST_DEBUG;
      else if (p == PORT_DMAD) return MST_DMA;
      else return MST_NONE;
   endfunction : portMaster

   // Matrix SRAM slave id of a RAM port
   function automatic sqa_slave_t portSlave(input logic [PW-1:0] p);
      if (p == PORT_CPU) return SLV_SRAM_CPU;
      else if (p == PORT_DEBUG) return SLV_SRAM_DBG;
      else if (p == PORT_DMAD) return SLV_SRAM_DMA;
      else return SLV_NONE;
   endfunction : portSlave

endpackage : sqa_pkg

// ---- verilog/sqa_qos_pick.sv ----
// Combinational winner selection among eligible RAM requests.
// Assumes eligibility already accounts for latency and grant masking.
`timescale 1ns/100ps
module sqa_qos_pick (
   // Candidates
   input  wire logic [sqa_pkg::NPORT-1:0]                  elig,
   input  wire sqa_pkg::sqa_level_t [sqa_pkg::NPORT-1:0]   lvl,
   // Result
   output logic                                             found,
   output logic [sqa_pkg::PW-1:0]                           winner
);
   import sqa_pkg::*;

   // Scan upward; only a strictly higher level displaces, so ties keep the lowest id
   always_comb begin
      sqa_level_t best;
      best   = LVL_BACKGROUND;
      found  = 1'b0;
      winner = '0;
      for (int j = 0; j < NPORT; j++) begin
         if (elig[j] && (!found || lvl[j] > best)) begin // R4 R5
            found  = 1'b1;
            best   = lvl[j];
            winner = PW'(j);
         end
      end
   end

endmodule : sqa_qos_pick

// ---- verilog/sqa_addr_decode.sv ----
// Fixed bus-matrix address decoder, region and slave id.
// Assumes a flat 32-bit byte address; nothing here is ever remapped.
`timescale 1ns/100ps
module sqa_addr_decode (
   // Address in
   input  wire logic [31:0]     addr,
   // Decode out
   output sqa_pkg::sqa_region_t region,
   output sqa_pkg::sqa_slave_t  slave
);
   import sqa_pkg::*;

   // True when a lies in [base, base+size)
   function automatic logic inside_of(input logic [31:0] a, input logic [31:0] base,
                                      input logic [31:0] size);
      return (a >= base) && ((a - base) < size);
   endfunction : inside_of

   // Constant map, no boot alias
   always_comb begin // R11
      if (inside_of(addr, BASE_FLASH, SIZE_FLASH)) begin // R12
         region = RGN_FLASH;
         slave  = SLV_FLASH;
      end else if (inside_of(addr, BASE_RWSEC, SIZE_RWSEC)) begin
         region = RGN_RWSEC;
         slave  = SLV_FLASH;
      end else if (inside_of(addr, BASE_SRAM, SIZE_SRAM)) begin
         region = RGN_SRAM;
         slave  = SLV_SRAM_CPU;
      end else if (inside_of(addr, BASE_BRIDGE_A, SIZE_BRIDGE)) begin // R14
         region = RGN_BRIDGE_A;
         slave  = SLV_BRIDGE_A;
      end else if (inside_of(addr, BASE_BRIDGE_B, SIZE_BRIDGE)) begin
         region = RGN_BRIDGE_B;
         slave  = SLV_BRIDGE_B;
      end else if (inside_of(addr, BASE_BRIDGE_C, SIZE_BRIDGE)) begin
         region = RGN_BRIDGE_C;
         slave  = SLV_BRIDGE_C;
      end else if (inside_of(addr, BASE_IOPORT, SIZE_IOPORT)) begin
         region = RGN_IOPORT;
         slave  = SLV_NONE;
      end else begin
         region = RGN_NONE;
         slave  = SLV_NONE;
      end
   end

endmodule : sqa_addr_decode

// ---- verilog/sqa_port_arbiter.sv ----
// SRAM port arbiter: nine requesters, service levels, AHB-Lite level registers.
// Assumes requesters hold request, address and data until granted, and a
// RAM that accepts one access per cycle while ramReady is high.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

// How it works
// [R1] Every RAM port has its own level, and each access carries it.
// [R2] Levels are two bits: background, bandwidth, latency, critical.
// [R3] Levels 0 and 1 wait at least one extra cycle before grant.
// [R4] Highest level wins; port number only breaks ties.
// [R5] Among equal levels, the smallest port number wins.
// [R6] Ports: cpu 0, debug 1, dma data 2, fetch 3-4, writeback 5-6; dma default 2.
// [R7] USB is direct port 7, default level 3.
// [R8] Trace buffer port 8 always carries level 3.
// [R9] CPU level in bits 1:0 at 0x4100c114, reset 3, word access only.
// [R10] Debug level in bits 1:0 at 0x4100201c, reset 2, word access only.
// [R11] Address decode is fixed and never remapped.
// [R12] Flash, rw section, sram, three bridges and io port at fixed bases.
// [R13] Matrix masters: cpu 0, debug 1, dma data 2.
// [R14] Matrix slaves: flash 0, sram ports 1 2 6, bridges B 3, A 4, C 5.
// [R15] Losers stall unchanged until granted; nothing is dropped.
// [R16] A new grant is decided every cycle the RAM is free.
module sqa_port_arbiter (
   // Clock and reset
   input  wire logic                                       sys_clk,
   input  wire logic                                       rst,
   // RAM requesters
   input  wire logic [sqa_pkg::NPORT-1:0]                  portReq,
   input  wire logic [sqa_pkg::NPORT-1:0]                  portWrite,
   input  wire logic [sqa_pkg::NPORT-1:0][sqa_pkg::RAM_AW-1:0] portAddr,
   input  wire logic [sqa_pkg::NPORT-1:0][31:0]            portWdata,
   output logic [sqa_pkg::NPORT-1:0]                       portGnt_r,
   // RAM side
   input  wire logic                                       ramReady,
   output logic                                            ramReq_r,
   output logic                                            ramWrite_r,
   output logic [sqa_pkg::RAM_AW-1:0]                      ramAddr_r,
   output logic [31:0]                                     ramWdata_r,
   output sqa_pkg::sqa_level_t                             ramLevel_r,
   output logic [sqa_pkg::PW-1:0]                          ramPort_r,
   output logic [1:0]                                      ramMaster_r,
   output sqa_pkg::sqa_slave_t                             ramSlave_r,
   // AHB-Lite register slave
   input  wire logic                                       hsel,
   input  wire logic [31:0]                                haddr,
   input  wire logic [1:0]                                 htrans,
   input  wire logic                                       hwrite,
   input  wire logic [2:0]                                 hsize,
   input  wire logic [31:0]                                hwdata,
   input  wire logic                                       hready,
   output logic                                            hreadyout,
   output logic [31:0]                                     hrdata,
   output logic                                            hresp
);
   import sqa_pkg::*;

   // ------------------------------------------------------------
   // Level registers
   // ------------------------------------------------------------
   sqa_level_t                cpuLevel_r;
   sqa_level_t                debugLevel_r;
   logic [7:0]                lvlCtrl_r;
   sqa_level_t [NPORT-1:0]    lvl;
   logic [NPORT-1:0]          waited_r;
   logic [NPORT-1:0]          elig;
   logic [NPORT-1:0]          gntNxt;
   logic                      found;
   logic [PW-1:0]             winner;
   logic                      grantNow;

   // Per-port level map; trace buffer is hard-wired critical
   always_comb begin
      lvl[0] = cpuLevel_r;                           // R1 R9
      lvl[1] = debugLevel_r;                         // R10
      lvl[2] = lvlCtrl_r[CTL_DMAD +: 2];             // R6
      lvl[3] = lvlCtrl_r[CTL_FTCH +: 2];
      lvl[4] = lvlCtrl_r[CTL_FTCH +: 2];
      lvl[5] = lvlCtrl_r[CTL_WRB +: 2];
      lvl[6] = lvlCtrl_r[CTL_WRB +: 2];
      lvl[7] = lvlCtrl_r[CTL_USB +: 2];              // R7
      lvl[8] = LVL_CRITICAL;                         // R8
   end

   // ------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------
   // Low levels must have been pending a cycle already; a port whose
   // grant pulse is out is masked so a held request is not served twice
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         elig[p] = portReq[p] && !portGnt_r[p] &&
                   (lvl[p] >= LVL_LATENCY || waited_r[p]);   // R2 R3
      end
   end

   sqa_qos_pick u_pick (
      .elig   (elig),
      .lvl    (lvl),
      .found  (found),
      .winner (winner)
   );

   assign grantNow = ramReady && found;                      // R16
   always_comb begin
      gntNxt = '0;
      gntNxt[winner] = grantNow;
   end

   // Pending-age bit per port, cleared by its grant
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         waited_r <= '0;
      end else begin
         waited_r <= portReq & ~gntNxt & ~portGnt_r;         // R3 R15
      end
   end

   // Grant pulse back to the requester
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         portGnt_r <= '0;
      end else begin
         portGnt_r <= gntNxt;                                // R15
      end
   end

   // Launch the access with the winner's level and matrix identity
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ramReq_r    <= 1'b0;
         ramWrite_r  <= 1'b0;
         ramAddr_r   <= '0;
         ramWdata_r  <= '0;
         ramLevel_r  <= LVL_BACKGROUND;
         ramPort_r   <= '0;
         ramMaster_r <= MST_NONE;
         ramSlave_r  <= SLV_NONE;
      end else begin
         ramReq_r <= grantNow;                               // R16
         if (grantNow) begin
            ramWrite_r  <= portWrite[winner];
            ramAddr_r   <= portAddr[winner];
            ramWdata_r  <= portWdata[winner];
            ramLevel_r  <= lvl[winner];                      // R1
            ramPort_r   <= winner;
            ramMaster_r <= portMaster(winner);               // R13
            ramSlave_r  <= portSlave(winner);                // R14
         end
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite register slave
   // ------------------------------------------------------------
   sqa_region_t   region;
   sqa_slave_t    slave;
   logic          apValid;
   logic          wrPend_r;
   logic [31:0]   wrAddr_r;
   logic          hitCpu;
   logic          hitDebug;
   logic          hitCtrl;

   sqa_addr_decode u_dec (
      .addr   (haddr),
      .region (region),
      .slave  (slave)
   );

   // Registers answer only in bridge B, only to whole-word transfers
   assign apValid  = hsel && hready && htrans[1] && slave == SLV_BRIDGE_B
                     && hsize == HSIZE_WORD;                 // R9 R10
   assign hitCpu   = wrAddr_r == ADDR_CPU_LVL;
   assign hitDebug = wrAddr_r == ADDR_DEBUG_LVL;
   assign hitCtrl  = wrAddr_r == ADDR_LVL_CTRL;

   // Capture the write address phase
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
      end else begin
         wrPend_r <= apValid && hwrite;
         if (apValid && hwrite) begin
            wrAddr_r <= haddr;
         end
      end
   end

   // Data phase write into the level registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cpuLevel_r   <= RST_CPU_LVL;                        // R9
         debugLevel_r <= RST_DEBUG_LVL;                      // R10
         lvlCtrl_r    <= RST_LVL_CTRL;                       // R6 R7
      end else if (wrPend_r) begin
         if (hitCpu) begin
            cpuLevel_r <= hwdata[1:0];                       // R9
         end else if (hitDebug) begin
            debugLevel_r <= hwdata[1:0];                     // R10
         end else if (hitCtrl) begin
            lvlCtrl_r <= hwdata[7:0];
         end
      end
   end

   // Read data is registered at the address phase, so no wait states
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hrdata    <= '0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= '0;
         if (apValid && !hwrite) begin
            if (haddr == ADDR_CPU_LVL) begin
               hrdata <= {30'h0, cpuLevel_r};
            end else if (haddr == ADDR_DEBUG_LVL) begin
               hrdata <= {30'h0, debugLevel_r};
            end else if (haddr == ADDR_LVL_CTRL) begin
               hrdata <= {24'h0, lvlCtrl_r};
            end else if (haddr == ADDR_STATUS) begin
               hrdata <= {16'h0, 7'h0, ramReq_r, ramLevel_r, 2'h0, ramPort_r};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [NPORT-1:0] reqD1_r;
   logic [NPORT-1:0] reqD2_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reqD1_r <= '0;
         reqD2_r <= '0;
      end else begin
         reqD1_r <= portReq;
         reqD2_r <= reqD1_r;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_cpu_wr;
      hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD
      && haddr == ADDR_CPU_LVL;
   endsequence
   sequence s_dbg_narrow_wr;
      hsel && hready && htrans[1] && hwrite && hsize != HSIZE_WORD
      && haddr == ADDR_DEBUG_LVL;
   endsequence

   property p_one_grant;
      $onehot0(portGnt_r) && (ramReq_r == (portGnt_r != '0));
   endproperty
   a_one_grant : assert property (p_one_grant) else $error("grant not single"); // R15

   property p_fresh_grant;
      ramReady && found |=> ramReq_r && ramPort_r == $past(winner);
   endproperty
   a_fresh_grant : assert property (p_fresh_grant) else $error("free RAM idle"); // R16

   property p_level_order;
      ramReq_r |-> !$past(elig[0] && lvl[0] > lvl[winner]) && ramLevel_r >= $past(lvl[8] & {2{elig[8]}});
   endproperty
   a_level_order : assert property (p_level_order) else $error("lower level won"); // R4

   property p_tie_low_id;
      ramReq_r && ramPort_r != '0 |-> !$past(elig[0] && lvl[0] == lvl[winner]);
   endproperty
   a_tie_low_id : assert property (p_tie_low_id) else $error("tie not to low id"); // R5

   property p_low_latency;
      ramReq_r && ramLevel_r < LVL_LATENCY |-> reqD2_r[ramPort_r];
   endproperty
   a_low_latency : assert property (p_low_latency) else $error("low level too fast"); // R3

   property p_trace_level;
      ramReq_r && ramPort_r == PORT_TRACE |-> ramLevel_r == LVL_CRITICAL;
   endproperty
   a_trace_level : assert property (p_trace_level) else $error("trace level wrong"); // R8

   property p_cpu_write;
      s_cpu_wr ##1 1'b1 |=> cpuLevel_r == $past(hwdata[1:0]);
   endproperty
   a_cpu_write : assert property (p_cpu_write) else $error("cpu level not written"); // R9

   property p_dbg_narrow;
      s_dbg_narrow_wr |-> ##2 $stable(debugLevel_r);
   endproperty
   a_dbg_narrow : assert property (p_dbg_narrow) else $error("narrow write took"); // R10

   // Wrap-around subtraction keeps the range test to one compare
   property p_sram_decode;
      hsel && htrans[1] && (haddr - BASE_SRAM) < SIZE_SRAM |-> region == RGN_SRAM;
   endproperty
   a_sram_decode : assert property (p_sram_decode) else $error("sram not decoded"); // R12

endmodule : sqa_port_arbiter

// ---- dv/sqa_req_model.sv ----
// Requester model: one RAM port master that holds its access until granted.
// Assumes the testbench pulses start for one cycle with the access fields.
`timescale 1ns/100ps
module sqa_req_model (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Testbench side
   input  wire logic                       start,
   input  wire logic                       wrIn,
   input  wire logic [sqa_pkg::RAM_AW-1:0] addrIn,
   input  wire logic [31:0]                dataIn,
   // Arbiter side
   input  wire logic                       gnt,
   output logic                            req,
   output logic                            write,
   output logic [sqa_pkg::RAM_AW-1:0]      addr,
   output logic [31:0]                     wdata
);
   // Fields held until the grant, then inverted so stale values never pass
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req <= 1'b0;
         write <= 1'b0;
         addr <= '0;
         wdata <= '0;
      end else if (start) begin
         req <= 1'b1;
         write <= wrIn;
         addr <= addrIn;
         wdata <= dataIn;
      end else if (gnt) begin
         req <= 1'b0;
         write <= ~write;
         addr <= ~addr;
         wdata <= ~wdata;
      end
   end
endmodule : sqa_req_model

// ---- dv/sqa_port_arbiter_tb.sv ----
// Testbench for the SRAM port arbiter: register access, latency, ordering.
// Assumes a zero-wait AHB-Lite slave and requesters that hold until granted.
`timescale 1ns/100ps
module sqa_port_arbiter_tb;
   import sqa_pkg::*;
   logic sys_clk, rst, ramReady, hsel, hwrite;
   logic [31:0] haddr, hwdata, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [NPORT-1:0] start;
   wire  [NPORT-1:0] portReq, portWrite, portGnt_r;
   wire  [NPORT-1:0][RAM_AW-1:0] portAddr;
   wire  [NPORT-1:0][31:0] portWdata;
   wire  ramReq_r, ramWrite_r, hreadyout, hresp;
   wire  [RAM_AW-1:0] ramAddr_r;
   wire  [31:0] ramWdata_r, hrdata;
   wire  sqa_level_t ramLevel_r;
   wire  [PW-1:0] ramPort_r;
   wire  [1:0] ramMaster_r;
   wire  sqa_slave_t ramSlave_r;
   int   nMismatch = 0;
   int   nChecks = 0;
   logic [PW-1:0] grantQ[$];
   logic [1:0] lvlExp [NPORT];
   logic [1:0] mstExp [NPORT] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
   logic [2:0] slvExp [NPORT] = '{3'h1, 3'h2, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};

   sqa_port_arbiter dut_u (.sys_clk(sys_clk), .rst(rst), .portReq(portReq),
      .portWrite(portWrite), .portAddr(portAddr), .portWdata(portWdata),
      .portGnt_r(portGnt_r), .ramReady(ramReady), .ramReq_r(ramReq_r),
      .ramWrite_r(ramWrite_r), .ramAddr_r(ramAddr_r), .ramWdata_r(ramWdata_r),
      .ramLevel_r(ramLevel_r), .ramPort_r(ramPort_r), .ramMaster_r(ramMaster_r),
      .ramSlave_r(ramSlave_r), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

   // One requester per RAM port; odd ports write, even ports read
   for (genvar i = 0; i < NPORT; i++) begin : g_req
      sqa_req_model req_u (.sys_clk(sys_clk), .rst(rst), .start(start[i]),
         .wrIn(1'(i % 2)), .addrIn(RAM_AW'(32'h100 + i)), .dataIn(32'h5a00_0000 + 32'(i)),
         .gnt(portGnt_r[i]), .req(portReq[i]), .write(portWrite[i]),
         .addr(portAddr[i]), .wdata(portWdata[i]));
   end

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         nMismatch++;
      end
   endtask : chk

   task automatic results;
      $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
      if (nMismatch == 0 && nChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // Every access is watched at the edge that samples its strobe
   always @(posedge sys_clk) begin
      if (rst === 1'b0 && ramReq_r === 1'b1) begin
         grantQ.push_back(ramPort_r);
         chk(32'(ramLevel_r), 32'(lvlExp[ramPort_r]));
         chk(32'(portGnt_r), 32'(9'h001 << ramPort_r));
         chk(32'(ramAddr_r), 32'(15'h0100 + ramPort_r));
         chk(ramWdata_r, 32'h5a00_0000 + 32'(ramPort_r));
         chk(32'(ramWrite_r), 32'(ramPort_r[0]));
         chk(32'(ramMaster_r), 32'(mstExp[ramPort_r]));
         chk(32'(ramSlave_r), 32'(slvExp[ramPort_r]));
      end
   end

   // ----------------------------------------------------------------
   // Bus tasks: zero wait expected, but every wait stays bounded
   // ----------------------------------------------------------------
   task automatic waitReady;
      int i;
      i = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && i < 50) begin
         i++;
         @(posedge sys_clk);
      end
      if (i >= 50) begin
         nMismatch++;
         results();
      end
   endtask : waitReady

   task automatic ahbWrite(input logic [31:0] a, input logic [31:0] v, input logic [2:0] sz);
      @(posedge sys_clk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      hsize <= sz;
      waitReady();
      htrans <= 2'h0;
      hwdata <= v;
      waitReady();
   endtask : ahbWrite

   task automatic ahbRead(input logic [31:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      hsize <= HSIZE_WORD;
      waitReady();
      htrans <= 2'h0;
      waitReady();
      v = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : ahbRead

   // Cycles from request raise (counted from the start edge) to grant seen
   task automatic lat(input int p, input int e);
      int n;
      @(posedge sys_clk);
      start <= 9'h001 << p;
      @(posedge sys_clk);
      start <= '0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (portGnt_r[p] !== 1'b1 && n < 20);
      chk(n, e);
   endtask : lat

   // All ports pend while RAM is busy, then drain back to back
   task automatic arb(input logic [3:0] e [NPORT]);
      grantQ.delete();
      @(posedge sys_clk);
      ramReady <= 1'b0;
      start <= 9'h1ff;
      @(posedge sys_clk);
      start <= '0;
      repeat (3) @(posedge sys_clk);
      chk(grantQ.size(), 0);
      ramReady <= 1'b1;
      repeat (20) @(posedge sys_clk);
      chk(grantQ.size(), 9);
      foreach (e[i]) chk(32'(grantQ[i]), 32'(e[i]));
   endtask : arb

   initial begin
      rst = 1'b1;
      start = '0;
      ramReady = 1'b1;
      hsel = 1'b1;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = '0;
      lvlExp = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      ahbRead(ADDR_CPU_LVL, d);
      chk(d, 32'h3);
      ahbRead(ADDR_DEBUG_LVL, d);
      chk(d, 32'h2);
      ahbRead(ADDR_LVL_CTRL, d);
      chk(d, 32'hea);
      ahbRead(32'h4100_c120, d);
      chk(d, 32'h0);
      ahbRead(BASE_SRAM + 32'h10, d);
      chk(d, 32'h0);
      lat(0, 2);
      ahbWrite(ADDR_CPU_LVL, 32'hffff_fffc, HSIZE_WORD);
      lvlExp[0] = 2'h0;
      lat(0, 3);
      ahbWrite(ADDR_CPU_LVL, 32'h1, HSIZE_WORD);
      lvlExp[0] = 2'h1;
      lat(0, 3);
      ahbWrite(ADDR_CPU_LVL, 32'h3, 3'h0);
      ahbRead(ADDR_CPU_LVL, d);
      chk(d, 32'h1);
      ahbWrite(ADDR_CPU_LVL, 32'hffff_ffff, HSIZE_WORD);
      ahbRead(ADDR_CPU_LVL, d);
      chk(d, 32'h3);
      lvlExp[0] = 2'h3;
      arb('{4'h0, 4'h7, 4'h8, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6});
      // Last access was port 6 at level 2, strobe since gone
      ahbRead(ADDR_STATUS, d);
      chk(d, 32'h86);
      // Every level code in use, ties split by port number
      ahbWrite(ADDR_CPU_LVL, 32'h0, HSIZE_WORD);
      ahbWrite(ADDR_DEBUG_LVL, 32'h1, HSIZE_WORD);
      ahbWrite(ADDR_LVL_CTRL, 32'h2d, HSIZE_WORD);
      ahbWrite(ADDR_DEBUG_LVL, 32'h3, 3'h1);
      ahbRead(ADDR_DEBUG_LVL, d);
      chk(d, 32'h1);
      lvlExp = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h3};
      arb('{4'h3, 4'h4, 4'h8, 4'h5, 4'h6, 4'h1, 4'h2, 4'h0, 4'h7});
      results();
   end
endmodule : sqa_port_arbiter_tb
